// File: src/irmsc_top.sv
// IR modulator, NVM write-protect and pin-function configuration.
// Assumes every input, PWM and serial included, is same-clock logic.
// Functional notes
// - Reset sets both write-protect bits
// - Separate gates for program and information memory
// - Enable routes modulator, else GPIO passes
// - ASK: first PWM carrier, second envelope
// - FSK: PWMs are two offset frequencies
// - Mode bit selects ASK or FSK
// - Polarity bit inverts modulator output at pin; GPIO bypass is not inverted
// - Source bit picks serial or software data
// - Hardware source shifts 8-bit characters out
// - Software source modulates software data bit
// - Analog bit disables digital I/O pin
// - LCD bit swaps pins to LCD power
`timescale 1ns/10ps
module irmsc_top
  import irmsc_pkg::*;
#(
  parameter int CHAR_W = 8,
  parameter int BIT_DIV = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire irmsc_bus_s bus,
  output logic [15:0] rdata,
  input wire logic pwm_first,
  input wire logic pwm_second,
  input wire logic ser_valid,
  output logic ser_ready,
  input wire logic [CHAR_W-1:0] ser_data,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic ir_pin_out,
  output logic ir_pin_oe,
  input wire logic [1:0] nvm_wr_req,
  output logic [1:0] nvm_wr_grant,
  output logic [IRMSC_N_ANA-1:0] analog_pin_control,
  output logic lcd_power_pin_control,
  output logic ir_busy
);
  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic program_write_protect_q;
  logic data_write_protect_q;
  irmsc_ircfg_s cfg_q;
  logic [IRMSC_N_ANA-1:0] ana_q;
  logic lcd_q;
  logic [15:0] rdata_q;
  logic pw_ok;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  assign pw_ok = bus.wdata[IRMSC_PW_LSB +: 8] == IRMSC_PASSWORD;

  // Protect bits only change with the password byte present
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      program_write_protect_q <= IRMSC_RST_CFG0[IRMSC_B_PWP];
      data_write_protect_q <= IRMSC_RST_CFG0[IRMSC_B_DWP];
    end else if (bus.wr && hit(bus.addr, IRMSC_OFS_CFG0) && pw_ok) begin
      program_write_protect_q <= bus.wdata[IRMSC_B_PWP];
      data_write_protect_q <= bus.wdata[IRMSC_B_DWP];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= irmsc_ircfg_s'(IRMSC_RST_CFG1);
    end else if (bus.wr && hit(bus.addr, IRMSC_OFS_CFG1)) begin
      cfg_q.infrared_enable <= bus.wdata[IRMSC_B_INFRARED_ENABLE];
      cfg_q.modulation_mode_select <= bus.wdata[IRMSC_B_MSEL];
      cfg_q.output_polarity_select <= bus.wdata[IRMSC_B_PSEL];
      cfg_q.data_source_select <= bus.wdata[IRMSC_B_DSSEL];
      cfg_q.software_data_bit <= bus.wdata[IRMSC_B_DATA];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ana_q <= IRMSC_RST_CFG2[IRMSC_N_ANA-1:0];
      lcd_q <= IRMSC_RST_CFG2[IRMSC_B_LCDP];
    end else if (bus.wr && hit(bus.addr, IRMSC_OFS_CFG2)) begin
      ana_q <= bus.wdata[IRMSC_N_ANA-1:0];
      lcd_q <= bus.wdata[IRMSC_B_LCDP];
    end
  end

  // ----------------------------------------------------------------------
  // Write-protect gate
  // ----------------------------------------------------------------------
  logic [1:0] grant_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      grant_q <= 2'b00;
    end else begin
      grant_q[0] <= nvm_wr_req[0] && !program_write_protect_q;
      grant_q[1] <= nvm_wr_req[1] && !data_write_protect_q;
    end
  end
  assign nvm_wr_grant = grant_q;

  // ----------------------------------------------------------------------
  // Pin-function controls, registered straight to ports
  // ----------------------------------------------------------------------
  assign analog_pin_control = ana_q;
  assign lcd_power_pin_control = lcd_q;

  // ----------------------------------------------------------------------
  // Serial character path
  // ----------------------------------------------------------------------
  logic bvalid;
  logic bready;
  logic [CHAR_W-1:0] bdata;

  irmsc_buf2 #(.W(CHAR_W)) u_buf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(ser_valid),
    .in_ready(ser_ready),
    .in_data(ser_data),
    .out_valid(bvalid),
    .out_ready(bready),
    .out_data(bdata)
  );

  // Bit-time enable from a divider; one cycle pulse
  logic [15:0] div_q;
  logic bit_tick;
  assign bit_tick = div_q == 16'(BIT_DIV - 1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 16'h0000;
    end else if (bit_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  irmsc_shift_e st_q;
  logic [CHAR_W-1:0] sh_q;
  logic [3:0] bits_q;
  logic hw_mode;
  assign hw_mode = cfg_q.infrared_enable && !cfg_q.data_source_select;
  // Characters drain only while the hardware source is live
  assign bready = hw_mode && (st_q == IRMSC_IDLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= IRMSC_IDLE;
      sh_q <= '0;
      bits_q <= 4'h0;
    end else begin
      case (st_q)
        IRMSC_IDLE: begin
          if (bvalid && bready) begin
            sh_q <= bdata;
            bits_q <= 4'(CHAR_W);
            st_q <= IRMSC_HOLD;
          end
        end
        IRMSC_HOLD: begin
          // Align first bit to a bit boundary
          if (bit_tick) begin
            st_q <= IRMSC_SHIFT;
          end
        end
        IRMSC_SHIFT: begin
          if (bit_tick) begin
            sh_q <= sh_q >> 1;
            bits_q <= bits_q - 4'h1;
            if (bits_q == 4'h1) begin
              st_q <= IRMSC_IDLE;
            end
          end
        end
        default: begin
          st_q <= IRMSC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Modulator
  // ----------------------------------------------------------------------
  logic hw_bit;
  logic dbit;
  logic mod;
  logic pin_d;
  logic pin_q;
  logic oe_q;
  logic busy_q;
  assign hw_bit = (st_q == IRMSC_SHIFT) && sh_q[0];

  always_comb begin
    // Zero selects hardware data and ASK
    dbit = cfg_q.data_source_select ? cfg_q.software_data_bit
                                    : hw_bit;
    if (!cfg_q.modulation_mode_select) begin
      mod = dbit && pwm_first && pwm_second;
    end else begin
      mod = dbit ? pwm_second : pwm_first;
    end
    pin_d = cfg_q.infrared_enable
          ? (mod ^ cfg_q.output_polarity_select)
          : gpio_out;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q <= cfg_q.infrared_enable | gpio_oe;
      busy_q <= st_q != IRMSC_IDLE;
    end
  end
  assign ir_pin_out = pin_q;
  assign ir_pin_oe = oe_q;
  assign ir_busy = busy_q;

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        IRMSC_OFS_CFG0:
          rdata_q <= {14'h0000, data_write_protect_q,
                      program_write_protect_q};
        IRMSC_OFS_CFG1:
          rdata_q <= {11'h000, cfg_q.software_data_bit,
                      cfg_q.data_source_select,
                      cfg_q.output_polarity_select,
                      cfg_q.modulation_mode_select,
                      cfg_q.infrared_enable};
        IRMSC_OFS_CFG2:
          rdata_q <= {3'h0, lcd_q, ana_q};
        IRMSC_OFS_STAT:
          rdata_q <= {13'h0000, bvalid, pin_q, busy_q};
        default:
          rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Pin checks look one cycle on, past the output register
  a_reset_protect: assert property (@(posedge clk)
    $rose(rstn) |-> program_write_protect_q && data_write_protect_q)
    else $error("protect bits not set after reset");

  a_password_hold: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && hit(bus.addr, IRMSC_OFS_CFG0) && !pw_ok)
    |=> $stable(program_write_protect_q) && $stable(data_write_protect_q))
    else $error("protect bits changed without password");

  a_prog_gate: assert property (@(posedge clk) disable iff (!rstn)
    program_write_protect_q |=> !nvm_wr_grant[0])
    else $error("program write granted while protected");

  a_prog_open: assert property (@(posedge clk) disable iff (!rstn)
    (nvm_wr_req[0] && !program_write_protect_q) |=> nvm_wr_grant[0])
    else $error("program write not granted");

  a_data_gate: assert property (@(posedge clk) disable iff (!rstn)
    (nvm_wr_req[1] && !data_write_protect_q) |=> nvm_wr_grant[1])
    else $error("data write not granted");

  a_data_shut: assert property (@(posedge clk) disable iff (!rstn)
    data_write_protect_q |=> !nvm_wr_grant[1])
    else $error("data write granted while protected");

  a_bypass_gpio: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_q.infrared_enable |=> ir_pin_out == $past(gpio_out))
    else $error("gpio not passed in bypass");

  a_oe_follow: assert property (@(posedge clk) disable iff (!rstn)
    cfg_q.infrared_enable |=> ir_pin_oe)
    else $error("pin not driven while modulating");

  a_ask_output: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.infrared_enable && !cfg_q.modulation_mode_select &&
     !cfg_q.output_polarity_select && !dbit) |=> !ir_pin_out)
    else $error("ask output active with data low");

  a_ask_carrier: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.infrared_enable && !cfg_q.modulation_mode_select &&
     !cfg_q.output_polarity_select && dbit)
    |=> ir_pin_out == $past(pwm_first && pwm_second))
    else $error("ask output not carrier and envelope");

  a_fsk_select: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.infrared_enable && cfg_q.modulation_mode_select &&
     !cfg_q.output_polarity_select && !dbit)
    |=> ir_pin_out == $past(pwm_first))
    else $error("fsk did not pick first pwm");

  a_fsk_second: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.infrared_enable && cfg_q.modulation_mode_select &&
     !cfg_q.output_polarity_select && dbit)
    |=> ir_pin_out == $past(pwm_second))
    else $error("fsk did not pick second pwm");

  a_polarity_inv: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.infrared_enable && cfg_q.output_polarity_select)
    |=> ir_pin_out == !$past(mod))
    else $error("polarity not inverted");

  a_sw_output: assert property (@(posedge clk) disable iff (!rstn)
    (cfg_q.infrared_enable && cfg_q.data_source_select &&
     !cfg_q.modulation_mode_select && !cfg_q.output_polarity_select &&
     pwm_first && pwm_second)
    |=> ir_pin_out == $past(cfg_q.software_data_bit))
    else $error("software bit not used");

  a_char_len: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == IRMSC_IDLE && bvalid && bready)
    |=> bits_q == 4'(CHAR_W))
    else $error("character length wrong");

  a_busy_flag: assert property (@(posedge clk) disable iff (!rstn)
    (st_q != IRMSC_IDLE) |=> ir_busy)
    else $error("busy flag low while shifting");

  a_analog_write: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && hit(bus.addr, IRMSC_OFS_CFG2))
    |=> analog_pin_control == $past(bus.wdata[IRMSC_N_ANA-1:0]))
    else $error("analog pin control not written");

  a_lcd_write: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && hit(bus.addr, IRMSC_OFS_CFG2))
    |=> lcd_power_pin_control == $past(bus.wdata[IRMSC_B_LCDP]))
    else $error("lcd power control not written");
endmodule

// File: include/irmsc_pkg.sv
// Package for the IR modulator / system configuration block.
// Assumes a plain register port with 16-bit data and one 40 MHz clock.
package irmsc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] IRMSC_OFS_CFG0 = 4'h0;
  localparam logic [3:0] IRMSC_OFS_CFG1 = 4'h2;
  localparam logic [3:0] IRMSC_OFS_CFG2 = 4'h4;
  localparam logic [3:0] IRMSC_OFS_STAT = 4'h6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IRMSC_B_PWP = 0;
  localparam int IRMSC_B_DWP = 1;
  localparam int IRMSC_B_INFRARED_ENABLE = 0;
  localparam int IRMSC_B_MSEL = 1;
  localparam int IRMSC_B_PSEL = 2;
  localparam int IRMSC_B_DSSEL = 3;
  localparam int IRMSC_B_DATA = 4;
  localparam int IRMSC_B_LCDP = 12;
  localparam int IRMSC_N_ANA = 12;
  localparam logic [7:0] IRMSC_PASSWORD = 8'hA5;
  localparam int IRMSC_PW_LSB = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] IRMSC_RST_CFG0 = 2'h3;
  localparam logic [4:0] IRMSC_RST_CFG1 = 5'h00;
  localparam logic [12:0] IRMSC_RST_CFG2 = 13'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } irmsc_bus_s;

  typedef struct packed {
    logic infrared_enable;
    logic modulation_mode_select;
    logic output_polarity_select;
    logic data_source_select;
    logic software_data_bit;
  } irmsc_ircfg_s;

  typedef enum logic [2:0] {
    IRMSC_IDLE = 3'b001,
    IRMSC_SHIFT = 3'b010,
    IRMSC_HOLD = 3'b100
  } irmsc_shift_e;

endpackage

// File: src/irmsc_buf2.sv
// Two-entry valid/ready buffer for serial characters.
// Assumes both sides run on clk; source holds data while valid and not ready.
`timescale 1ns/10ps
module irmsc_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic rdy_q;
  logic push;
  logic pop;

  assign push = in_valid && (cnt_q != 2'd2);
  assign pop = out_valid && out_ready;
  // Ready registered so the top port comes straight from a flop
  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'd1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'd0;
      rdy_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != 2'd2);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  a_no_overflow: assert property (@(posedge clk) disable iff (!rstn)
    (cnt_q == 2'd2) |-> !in_ready)
    else $error("buffer accepts when full");

  a_stall_hold: assert property (@(posedge clk) disable iff (!rstn)
    (out_valid && !out_ready) |=> out_valid && $stable(out_data))
    else $error("stalled word lost");
endmodule

// File: verif/irmsc_ir_drv.sv
// Model of the external IR driver circuit hanging on the modulator pin.
// Assumes the pin is sampled on clk and floats when not driven.
`timescale 1ns/10ps
module irmsc_ir_drv (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic line
);
  logic last_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_q <= 1'b0;
    end else if (pin_oe) begin
      last_q <= pin_out;
    end
  end

  // Undriven wire shows the inverse, so a stale level never passes
  assign line = pin_oe ? pin_out : ~last_q;
endmodule

// File: verif/test_ir_modulator_sys_config.sv
// Self-checking bench for the IR modulator / system configuration block.
// Assumes one 40 MHz clock and the plain register port of the package.
`timescale 1ns/10ps
module test_ir_modulator_sys_config
  import irmsc_pkg::*;
;
  localparam int BD = 2;
  logic clk, rstn, pwm_first, pwm_second, ser_valid, gpio_out, gpio_oe;
  logic ser_ready, ir_pin_out, ir_pin_oe, lcd_power_pin_control, ir_busy;
  logic line;
  logic [7:0] ser_data;
  logic [15:0] rdata, v;
  logic [1:0] nvm_wr_req, nvm_wr_grant;
  logic [11:0] analog_pin_control;
  irmsc_bus_s bus;
  int err_count, compares, cyc;

  irmsc_top #(.CHAR_W(8), .BIT_DIV(BD)) uut (.clk(clk), .rstn(rstn),
    .bus(bus), .rdata(rdata), .pwm_first(pwm_first),
    .pwm_second(pwm_second), .ser_valid(ser_valid), .ser_ready(ser_ready),
    .ser_data(ser_data), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .ir_pin_out(ir_pin_out), .ir_pin_oe(ir_pin_oe),
    .nvm_wr_req(nvm_wr_req), .nvm_wr_grant(nvm_wr_grant),
    .analog_pin_control(analog_pin_control),
    .lcd_power_pin_control(lcd_power_pin_control), .ir_busy(ir_busy));
  irmsc_ir_drv drv (.clk(clk), .rstn(rstn), .pin_out(ir_pin_out),
    .pin_oe(ir_pin_oe), .line(line));

  always #12.5 clk = ~clk;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task close_out;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask

  task grant(input logic [1:0] r, input logic [1:0] exp);
    @(posedge clk);
    nvm_wr_req <= r;
    @(posedge clk);
    nvm_wr_req <= 2'b00;
    #1 chk("grant", {14'h0000, nvm_wr_grant}, {14'h0000, exp});
  endtask

  task push(input logic [7:0] d);
    logic ok;
    @(posedge clk);
    ser_data <= d;
    ser_valid <= 1'b1;
    repeat (50) begin
      #1 ok = ser_ready;
      @(posedge clk);
      if (ok) break;
    end
    ser_valid <= 1'b0;
    chk("push taken", {15'h0000, ok}, 16'h0001);
  endtask

  // Bit phase is found from the first high bit, so chars start with a 1
  task rxchar(input logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (line !== 1'b1 && n < 100);
    chk("busy", {15'h0000, ir_busy}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      chk("hw bit", {15'h0000, line}, {15'h0000, d[i]});
      repeat (BD) @(posedge clk);
      #1;
    end
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_reset;
    rd(IRMSC_OFS_CFG0);
    chk("cfg0", v, 16'h0003);
    rd(IRMSC_OFS_CFG1);
    chk("cfg1", v, 16'h0000);
    rd(4'h8);
    chk("unmapped", v, 16'h0000);
    grant(2'b11, 2'b00);
  endtask

  task t_protect;
    wr(IRMSC_OFS_CFG0, 16'h0000);
    rd(IRMSC_OFS_CFG0);
    chk("no password", v, 16'h0003);
    wr(IRMSC_OFS_CFG0, 16'hA502);
    rd(IRMSC_OFS_CFG0);
    chk("cfg0 prog", v, 16'h0002);
    grant(2'b11, 2'b01);
    wr(IRMSC_OFS_CFG0, 16'hA501);
    grant(2'b11, 2'b10);
  endtask

  task t_pins;
    wr(IRMSC_OFS_CFG2, 16'h1A5C);
    #1 chk("analog", {4'h0, analog_pin_control}, 16'h0A5C);
    chk("lcd", {15'h0000, lcd_power_pin_control}, 16'h0001);
    wr(IRMSC_OFS_CFG2, 16'h0FFF);
    rd(IRMSC_OFS_CFG2);
    chk("cfg2", v, 16'h0FFF);
    chk("lcd off", {15'h0000, lcd_power_pin_control}, 16'h0000);
  endtask

  task t_gpio;
    wr(IRMSC_OFS_CFG1, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      gpio_out <= k[0];
      gpio_oe <= k[1];
      repeat (3) @(posedge clk);
      #1 chk("gpio out", {15'h0000, ir_pin_out}, {15'h0000, k[0]});
      chk("gpio oe", {15'h0000, ir_pin_oe}, {15'h0000, k[1]});
    end
    @(posedge clk);
    gpio_oe <= 1'b0;
  endtask

  task t_sw;
    logic e;
    for (int c = 0; c < 32; c++) begin
      @(posedge clk);
      pwm_first <= c[0];
      pwm_second <= c[1];
      wr(IRMSC_OFS_CFG1, {11'h000, c[2], 1'b1, c[4], c[3], 1'b1});
      e = c[3] ? (c[2] ? c[1] : c[0]) : (c[2] & c[0] & c[1]);
      repeat (3) @(posedge clk);
      #1 chk("sw mod", {15'h0000, line}, {15'h0000, e ^ c[4]});
      chk("ir oe", {15'h0000, ir_pin_oe}, 16'h0001);
    end
    rd(IRMSC_OFS_CFG1);
    chk("cfg1 back", v, 16'h001F);
  endtask

  task t_hw;
    wr(IRMSC_OFS_CFG1, 16'h0000);
    pwm_first <= 1'b1;
    pwm_second <= 1'b1;
    push(8'h2D);
    push(8'hC5);
    #1 chk("buffer full", {15'h0000, ser_ready}, 16'h0000);
    rd(IRMSC_OFS_STAT);
    chk("stat", v, 16'h0006);
    wr(IRMSC_OFS_CFG1, 16'h0001);
    rxchar(8'h2D);
    rxchar(8'hC5);
  endtask

  task t_rerst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(IRMSC_OFS_CFG0);
    chk("cfg0 again", v, 16'h0003);
    chk("analog reset", {4'h0, analog_pin_control}, 16'h0000);
    chk("oe reset", {15'h0000, ir_pin_oe}, 16'h0000);
  endtask

  // --------------------------------------------------------------------
  // Main sequence and hang guard
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    bus = '0;
    {pwm_first, pwm_second, ser_valid, gpio_out, gpio_oe} = 5'b00000;
    ser_data = 8'h00;
    nvm_wr_req = 2'b00;
    err_count = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_protect;
    t_pins;
    t_gpio;
    t_sw;
    t_hw;
    t_rerst;
    close_out;
  end
endmodule
